// ==== core/stop_and_coast_restart_control.sv ====
`timescale 1ns/10ps
module stop_and_coast_restart_control #(
  parameter int unsigned TENTH_CYC = stop_coast_pkg::TENTH_S_CYC
) (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // register port
  input wire stop_coast_pkg::reg_req_s reg_req_i,
  output logic [15:0] reg_rdata_o,
  // keypad and terminals
  input wire logic keypad_stop_key_i,
  input wire logic keypad_run_i,
  input wire logic forward_run_command_i,
  input wire logic [7:0] mf_in_i,
  input wire logic trip_i,
  // drive feedback
  input wire logic [15:0] set_freq_i,
  input wire logic [15:0] max_freq_i,
  input wire logic [15:0] base_freq_i,
  input wire logic [15:0] motor_freq_i,
  input wire logic [15:0] out_current_i,
  input wire logic induction_decayed_i,
  input wire logic volt_agree_i,
  input wire logic ramp_tick_i,
  // power stage
  output logic out_enable_o,
  output logic [15:0] out_freq_o,
  output logic [15:0] current_limit_o,
  output logic trip_reset_o,
  output logic [7:0] state_o
);
  import stop_coast_pkg::*;

  ctrl_s ctrl_q;
  logic [15:0] retry_q, floor_q, pcur_q, pdec_q, rdata_q;
  logic [7:0] term_func_q [NUM_TERMS];
  state_e state_q, state_d;
  logic [15:0] freq_q, freq_d, saved_freq_q;
  logic [31:0] tick_q;
  logic [15:0] tenth_q;
  logic [23:0] pstep_q;
  logic key_prev_q, run_latch_q, run_prev_q, stop_hold_q, coast_prev_q;
  logic trip_reset_q;

  // register decode
  wire is_term = reg_req_i.addr[4:3] == ADDR_TERM_BASE[4:3];
  wire [2:0] term_idx = reg_req_i.addr[2:0];

  // terminal function match, code 11 on any terminal
  logic [NUM_TERMS-1:0] coast_hit;
  genvar g;
  generate
    for (g = 0; g < NUM_TERMS; g++) begin : g_term
      assign coast_hit[g] = mf_in_i[g] && term_func_q[g] == FUNC_COAST;
    end
  endgenerate
  wire coast_in = |coast_hit;

  // command source and key permissions
  wire src_keypad = ctrl_q.run_source_select == SRC_KEYPAD;
  wire key_edge = keypad_stop_key_i && !key_prev_q;
  wire key_stop_en = src_keypad || ctrl_q.stop_key_select == KEY_BOTH;
  wire key_reset_en = src_keypad || ctrl_q.stop_key_select == KEY_BOTH
                      || ctrl_q.stop_key_select == KEY_RESET_ONLY;
  wire key_stop = key_edge && key_stop_en;
  wire key_reset = key_edge && key_reset_en && trip_i;
  wire run_raw = src_keypad ? run_latch_q : forward_run_command_i;
  wire run_cmd = run_raw && !stop_hold_q;
  wire run_rise = run_cmd && !run_prev_q;
  wire coast_release = coast_prev_q && !coast_in;

  // retry wait and pull-in step timers
  wire wait_done = tenth_q >= retry_q;
  wire [23:0] pstep_lim = 24'(pdec_q) * 24'(PULLIN_UNIT_CYC);
  wire pstep_due = pstep_q >= pstep_lim;
  wire cur_over = out_current_i >= pcur_q;
  wire [15:0] half_base = base_freq_i >> 1;
  wire match_low = motor_freq_i <= floor_q || motor_freq_i <= half_base
                   || induction_decayed_i;

  // pull-in starting frequency
  logic [15:0] pull_start;
  always_comb begin
    case (ctrl_q.pullin_start_freq_select)
      PSTART_INTERRUPT: pull_start = saved_freq_q;
      PSTART_MAX: pull_start = max_freq_i;
      default: pull_start = set_freq_i;
    endcase
  end

  // restart trigger out of coasting
  wire restart_go = run_cmd && !coast_in
                    && (run_rise || key_reset
                        || (coast_release && !src_keypad));

  // sequencing
  always_comb begin
    state_d = state_q;
    freq_d = freq_q;
    case (state_q)
      ST_IDLE: begin
        if (coast_in) begin
          state_d = ST_COAST;
        end else if (run_cmd) begin
          state_d = ST_RUN;
          freq_d = 16'h0000;
        end
      end
      ST_RUN: begin
        if (coast_in) begin
          state_d = ST_COAST;
        end else if (!run_cmd) begin
          if (ctrl_q.stop_mode_select == STOP_COAST) begin
            state_d = ST_COAST;
          end else begin
            state_d = ST_DECEL;
          end
        end else if (ramp_tick_i && freq_q < set_freq_i) begin
          freq_d = freq_q + 16'h0001;
        end else if (ramp_tick_i && freq_q > set_freq_i) begin
          freq_d = freq_q - 16'h0001;
        end
      end
      ST_DECEL: begin
        if (coast_in) begin
          state_d = ST_COAST;
        end else if (run_cmd) begin
          state_d = ST_RUN;
        end else if (freq_q == 16'h0000) begin
          state_d = ST_IDLE;
        end else if (ramp_tick_i) begin
          freq_d = freq_q - 16'h0001;
        end
      end
      ST_COAST: begin
        freq_d = 16'h0000;
        if (restart_go) begin
          if (ctrl_q.coast_restart_mode == RESTART_ZERO) begin
            state_d = ST_RUN;
          end else begin
            state_d = ST_WAIT;
          end
        end else if (coast_release && src_keypad) begin
          state_d = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (coast_in || !run_cmd) begin
          state_d = ST_COAST;
        end else if (wait_done) begin
          if (ctrl_q.coast_restart_mode == RESTART_MATCH) begin
            state_d = ST_MATCH;
          end else if (ctrl_q.coast_restart_mode == RESTART_PULLIN) begin
            state_d = ST_PULLIN;
            freq_d = pull_start;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_MATCH: begin
        state_d = ST_RUN;
        freq_d = match_low ? 16'h0000 : motor_freq_i;
      end
      ST_PULLIN: begin
        if (coast_in || !run_cmd) begin
          state_d = ST_COAST;
        end else if (volt_agree_i) begin
          state_d = ST_RUN;
        end else if (pstep_due && !cur_over && freq_q != 16'h0000) begin
          freq_d = freq_q - 16'h0001;
        end
      end
      default: begin
        state_d = ST_IDLE;
        freq_d = 16'h0000;
      end
    endcase
  end

  // state, frequency and saved interruption frequency
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      freq_q <= 16'h0000;
      saved_freq_q <= 16'h0000;
    end else if (en_i) begin
      state_q <= state_d;
      freq_q <= freq_d;
      if (state_d == ST_COAST && state_q != ST_COAST) begin
        saved_freq_q <= freq_q;
      end
    end
  end

  // retry wait counter, runs only in wait
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      tick_q <= 32'h00000000;
      tenth_q <= 16'h0000;
    end else if (en_i) begin
      if (state_q != ST_WAIT) begin
        tick_q <= 32'h00000000;
        tenth_q <= 16'h0000;
      end else if (tick_q >= TENTH_CYC - 1) begin
        tick_q <= 32'h00000000;
        tenth_q <= tenth_q + 16'h0001;
      end else begin
        tick_q <= tick_q + 32'h00000001;
      end
    end
  end

  // pull-in step pacing
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pstep_q <= 24'h000000;
    end else if (en_i) begin
      if (state_q != ST_PULLIN || pstep_due) begin
        pstep_q <= 24'h000000;
      end else begin
        pstep_q <= pstep_q + 24'h000001;
      end
    end
  end

  // input edges, keypad run latch, stop hold
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      key_prev_q <= 1'b0;
      run_latch_q <= 1'b0;
      run_prev_q <= 1'b0;
      stop_hold_q <= 1'b0;
      coast_prev_q <= 1'b0;
      trip_reset_q <= 1'b0;
    end else if (en_i) begin
      key_prev_q <= keypad_stop_key_i;
      run_prev_q <= run_cmd;
      coast_prev_q <= coast_in;
      trip_reset_q <= key_reset;
      if (keypad_run_i) begin
        run_latch_q <= 1'b1;
      end else if (key_stop || (coast_release && src_keypad)) begin
        run_latch_q <= 1'b0;
      end
      if (key_stop) begin
        stop_hold_q <= 1'b1;
      end else if (!run_raw || keypad_run_i) begin
        stop_hold_q <= 1'b0;
      end
    end
  end

  // register writes
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ctrl_q <= CTRL_RESET;
      retry_q <= RETRY_RESET;
      floor_q <= FLOOR_RESET;
      pcur_q <= PCUR_RESET;
      pdec_q <= PDEC_RESET;
    end else if (en_i && reg_req_i.we) begin
      case (reg_req_i.addr)
        ADDR_CTRL: ctrl_q <= {6'h00, reg_req_i.wdata[9:0]};
        ADDR_RETRY: retry_q <= reg_req_i.wdata;
        ADDR_FLOOR: floor_q <= reg_req_i.wdata;
        ADDR_PCUR: pcur_q <= reg_req_i.wdata;
        ADDR_PDEC: pdec_q <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  // terminal function registers
  generate
    for (g = 0; g < NUM_TERMS; g++) begin : g_func
      always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
          term_func_q[g] <= TERM_RESET;
        end else if (en_i && reg_req_i.we && is_term && term_idx == g) begin
          term_func_q[g] <= reg_req_i.wdata[7:0];
        end
      end
    end
  endgenerate

  // read mux
  logic [15:0] rmux;
  always_comb begin
    rmux = 16'h0000;
    if (is_term) begin
      rmux = {8'h00, term_func_q[term_idx]};
    end else begin
      case (reg_req_i.addr)
        ADDR_CTRL: rmux = ctrl_q;
        ADDR_RETRY: rmux = retry_q;
        ADDR_FLOOR: rmux = floor_q;
        ADDR_PCUR: rmux = pcur_q;
        ADDR_PDEC: rmux = pdec_q;
        ADDR_STATUS: rmux = {7'h00, out_enable_o, state_q};
        default: rmux = 16'h0000;
      endcase
    end
  end

  // read data one cycle later
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rdata_q <= 16'h0000;
    end else if (en_i) begin
      rdata_q <= reg_req_i.re ? rmux : 16'h0000;
    end
  end

  // outputs
  assign out_enable_o = state_q == ST_RUN || state_q == ST_DECEL
                        || state_q == ST_PULLIN;
  assign out_freq_o = freq_q;
  assign current_limit_o = pcur_q;
  assign trip_reset_o = trip_reset_q;
  assign state_o = state_q;
  assign reg_rdata_o = rdata_q;
endmodule

// ==== shared/stop_coast_pkg.sv ====
package stop_coast_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TENTH_S_NS = 100000000;
  localparam int unsigned TENTH_S_CYC = TENTH_S_NS / CLK_PERIOD_NS;
  localparam int unsigned PULLIN_UNIT_NS = 10000;
  localparam int unsigned PULLIN_UNIT_CYC = PULLIN_UNIT_NS / CLK_PERIOD_NS;
  // register indices
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_RETRY = 5'h01;
  localparam logic [4:0] ADDR_FLOOR = 5'h02;
  localparam logic [4:0] ADDR_PCUR = 5'h03;
  localparam logic [4:0] ADDR_PDEC = 5'h04;
  localparam logic [4:0] ADDR_STATUS = 5'h05;
  localparam logic [4:0] ADDR_TERM_BASE = 5'h08;
  localparam int unsigned NUM_TERMS = 8;
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] RETRY_RESET = 16'h000a;
  localparam logic [15:0] FLOOR_RESET = 16'h0000;
  localparam logic [15:0] PCUR_RESET = 16'h0064;
  localparam logic [15:0] PDEC_RESET = 16'h0032;
  localparam logic [7:0] TERM_RESET = 8'h00;
  // codes
  localparam logic [1:0] SRC_KEYPAD = 2'h2;
  localparam logic [1:0] KEY_BOTH = 2'h0;
  localparam logic [1:0] KEY_RESET_ONLY = 2'h2;
  localparam logic [1:0] STOP_DECEL = 2'h0;
  localparam logic [1:0] STOP_COAST = 2'h1;
  localparam logic [1:0] RESTART_ZERO = 2'h0;
  localparam logic [1:0] RESTART_MATCH = 2'h1;
  localparam logic [1:0] RESTART_PULLIN = 2'h2;
  localparam logic [1:0] PSTART_INTERRUPT = 2'h0;
  localparam logic [1:0] PSTART_MAX = 2'h1;
  localparam logic [7:0] FUNC_COAST = 8'h0b;

  // control register layout
  typedef struct packed {
    logic [5:0] unused;
    logic [1:0] pullin_start_freq_select;
    logic [1:0] coast_restart_mode;
    logic [1:0] stop_mode_select;
    logic [1:0] stop_key_select;
    logic [1:0] run_source_select;
  } ctrl_s;

  // register port request
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } reg_req_s;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RUN = 8'h02,
    ST_DECEL = 8'h04,
    ST_COAST = 8'h08,
    ST_WAIT = 8'h10,
    ST_MATCH = 8'h20,
    ST_PULLIN = 8'h40,
    ST_SPARE = 8'h80
  } state_e;
endpackage

// ==== verification/drive_model.sv ====
`timescale 1ns/10ps
module drive_model (
  // clock
  input wire logic core_clk_i,
  // power stage
  input wire logic out_enable_i,
  input wire logic [15:0] out_freq_i,
  // motor feedback
  output logic [15:0] motor_freq_o,
  output logic ramp_tick_o
);
  initial begin
    motor_freq_o = 16'h0000;
    ramp_tick_o = 1'b0;
  end
  // slow tick; motor follows drive, loses speed when free
  always @(posedge core_clk_i) begin
    ramp_tick_o <= ~ramp_tick_o;
    if (out_enable_i)
      motor_freq_o <= out_freq_i;
    else if (ramp_tick_o && motor_freq_o != 16'h0000)
      motor_freq_o <= motor_freq_o - 16'h0001;
  end
endmodule

// ==== verification/scrc_checker.sv ====
`timescale 1ns/10ps
module scrc_checker
  import stop_coast_pkg::*;
#(
  parameter int unsigned TENTH_CYC = 4
) (
  // clock, reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // watched inputs
  input wire logic keypad_stop_key_i,
  input wire logic trip_i,
  input wire logic [15:0] motor_freq_i,
  input wire logic volt_agree_i,
  // watched outputs
  input wire logic out_enable_o,
  input wire logic [15:0] out_freq_o,
  input wire logic trip_reset_o,
  input wire logic [7:0] state_o
);
  int unsigned wait_cnt_q;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // cycles spent in retry wait
  always_ff @(posedge core_clk_i) begin
    if (state_o != ST_WAIT)
      wait_cnt_q <= 0;
    else
      wait_cnt_q <= wait_cnt_q + 1;
  end
  // steps of the restart sequences
  sequence s_wait_done;
    $past(state_o) == ST_WAIT && state_o inside {ST_MATCH, ST_PULLIN};
  endsequence
  sequence s_pull_done;
    $past(state_o) == ST_PULLIN && state_o == ST_RUN;
  endsequence
  sequence s_key_reset;
    $past(trip_i) && $past(keypad_stop_key_i) &&
      !$past(keypad_stop_key_i, 2);
  endsequence
  property p_wait_len;
    s_wait_done |-> wait_cnt_q >= 3 * TENTH_CYC;
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("retry wait too short");
  property p_match_one;
    state_o == ST_MATCH |=> state_o == ST_RUN;
  endproperty
  a_match_one: assert property (p_match_one)
    else $error("match not followed by run");
  property p_match_freq;
    state_o == ST_MATCH |=>
      out_freq_o == $past(motor_freq_i) || out_freq_o == 16'h0000;
  endproperty
  a_match_freq: assert property (p_match_freq)
    else $error("match frequency wrong");
  property p_trip_cause;
    trip_reset_o |-> s_key_reset ##1 !trip_reset_o;
  endproperty
  a_trip_cause: assert property (p_trip_cause)
    else $error("trip reset without key edge");
  property p_off;
    state_o inside {ST_IDLE, ST_COAST, ST_WAIT} |-> !out_enable_o;
  endproperty
  a_off: assert property (p_off)
    else $error("output on while coasting");
  property p_decel_on;
    state_o == ST_DECEL |-> out_enable_o;
  endproperty
  a_decel_on: assert property (p_decel_on)
    else $error("output off in decel");
  property p_pull_exit;
    s_pull_done |-> $past(volt_agree_i);
  endproperty
  a_pull_exit: assert property (p_pull_exit)
    else $error("pull-in left without agreement");
  property p_pull_dec;
    state_o == ST_PULLIN && $past(state_o) == ST_PULLIN |->
      out_freq_o <= $past(out_freq_o);
  endproperty
  a_pull_dec: assert property (p_pull_dec)
    else $error("pull-in frequency rose");
endmodule

bind stop_and_coast_restart_control scrc_checker #(
  .TENTH_CYC(TENTH_CYC)
) u_chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .trip_i(trip_i),
  .keypad_stop_key_i(keypad_stop_key_i), .motor_freq_i(motor_freq_i),
  .volt_agree_i(volt_agree_i), .out_enable_o(out_enable_o),
  .out_freq_o(out_freq_o), .trip_reset_o(trip_reset_o),
  .state_o(state_o)
);

// ==== verification/test_stop_and_coast_restart_control.sv ====
`timescale 1ns/10ps
module test_stop_and_coast_restart_control;
  import stop_coast_pkg::*;
  logic clk, nrst, en, key, krun, fwd, trip, volt, dec, tick, oe, trst;
  logic [15:0] rdata, motor, ofreq, cur, exp_v;
  logic [7:0] mf, st;
  reg_req_s req;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  stop_and_coast_restart_control #(.TENTH_CYC(4)) uut (
    .core_clk_i(clk), .nrst_i(nrst), .en_i(en), .reg_req_i(req),
    .reg_rdata_o(rdata), .keypad_stop_key_i(key), .keypad_run_i(krun),
    .forward_run_command_i(fwd), .mf_in_i(mf), .trip_i(trip),
    .set_freq_i(16'h0040), .max_freq_i(16'h0100),
    .base_freq_i(16'h0010), .motor_freq_i(motor),
    .out_current_i(16'h0000), .induction_decayed_i(dec),
    .volt_agree_i(volt), .ramp_tick_i(tick), .out_enable_o(oe),
    .out_freq_o(ofreq), .current_limit_o(cur), .trip_reset_o(trst),
    .state_o(st));
  drive_model pm (
    .core_clk_i(clk), .out_enable_i(oe), .out_freq_i(ofreq),
    .motor_freq_o(motor), .ramp_tick_o(tick));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic ck();
    @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    num_checks++;
    if (got !== e) begin
      fail_count++;
      $display("Error %0t: got %h exp %h", $time, got, e);
    end
  endtask
  task automatic till(input logic f, input logic [15:0] v);
    n = 0;
    while ((f ? ofreq : 16'(st)) !== v && n < 600) begin
      ck();
      #1 n++;
    end
    if (n == 600) begin
      fail_count++;
      $display("Error %0t: wait ran out", $time);
      summarize();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    ck();
    req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    ck();
    req <= '0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    ck();
    req <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
    ck();
    req <= '0;
    #1 chk(rdata, e);
  endtask
  // key held two cycles, trip reset seen one cycle after
  task automatic press(input logic t, input logic e);
    ck();
    key <= 1'b1;
    trip <= t;
    ck();
    #1 chk(trst, e);
    ck();
    key <= 1'b0;
    trip <= 1'b0;
  endtask
  // run pulse latches, state follows one edge later
  task automatic kick();
    ck();
    krun <= 1'b1;
    ck();
    krun <= 1'b0;
    ck();
    #1;
  endtask
  // run at set speed, coast on terminal 3, release
  task automatic coast(input logic [15:0] c);
    wr(ADDR_CTRL, c);
    till(1'b1, 16'h0040);
    ck();
    mf <= 8'h08;
    ck();
    #1 chk(oe, 16'h0000);
    chk(st, ST_COAST);
    ck();
    mf <= 8'h00;
    ck();
    #1;
  endtask
  task automatic t_regs();
    rd(ADDR_CTRL, 16'h0000);
    rd(ADDR_RETRY, 16'h000a);
    rd(ADDR_PCUR, 16'h0064);
    rd(ADDR_PDEC, 16'h0032);
    rd(5'h06, 16'h0000);
  endtask
  task automatic t_match();
    ck();
    fwd <= 1'b1;
    wr(ADDR_TERM_BASE + 5'h03, 16'h000b);
    coast(16'h0000);
    chk(st, ST_RUN);
    chk(ofreq, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_FLOOR, (i == 1) ? 16'hffff : 16'h0000);
      dec <= (i == 2);
      coast(16'h0040);
      chk(st, ST_WAIT);
      n = 0;
      while (st !== ST_MATCH && n < 99) begin
        ck();
        #1 n++;
      end
      // retry of 10 tenths at 4 cycles each, plus the deciding edge
      chk(16'(n), 16'd41);
      exp_v = (i == 0) ? motor : 16'h0000;
      ck();
      #1 chk(st, ST_RUN);
      chk(ofreq, exp_v);
    end
  endtask
  task automatic t_pullin();
    for (int i = 0; i < 3; i++) begin
      coast(16'h0080 | (16'(i) << 8));
      till(1'b0, 16'(ST_PULLIN));
      chk(ofreq, (i == 1) ? 16'h0100 : 16'h0040);
      chk(cur, 16'h0064);
      ck();
      volt <= 1'b1;
      ck();
      volt <= 1'b0;
      #1 chk(st, ST_RUN);
    end
  endtask
  task automatic t_keys();
    wr(ADDR_CTRL, 16'h0004);
    press(1'b1, 1'b0);
    #1 chk(st, ST_RUN);
    wr(ADDR_CTRL, 16'h0008);
    press(1'b1, 1'b1);
    #1 chk(st, ST_RUN);
    wr(ADDR_CTRL, 16'h0000);
    press(1'b0, 1'b0);
    #1 chk(st, ST_DECEL);
    till(1'b0, 16'(ST_IDLE));
    chk(ofreq, 16'h0000);
    wr(ADDR_CTRL, 16'h0010);
    fwd <= 1'b0;
    ck();
    fwd <= 1'b1;
    till(1'b1, 16'h0040);
    ck();
    fwd <= 1'b0;
    ck();
    #1 chk(st, ST_COAST);
    ck();
    fwd <= 1'b1;
    ck();
    #1 chk(st, ST_RUN);
    chk(ofreq, 16'h0000);
  endtask
  task automatic t_keypad();
    wr(ADDR_CTRL, 16'h0006);
    kick();
    till(1'b1, 16'h0040);
    press(1'b0, 1'b0);
    #1 chk(st, ST_DECEL);
    kick();
    chk(st, ST_RUN);
    ck();
    mf <= 8'h08;
    ck();
    mf <= 8'h00;
    #1 chk(st, ST_COAST);
    ck();
    #1 chk(st, ST_IDLE);
    kick();
    chk(st, ST_RUN);
  endtask
  initial begin
    nrst = 1'b0;
    en = 1'b1;
    key = 1'b0;
    krun = 1'b0;
    fwd = 1'b0;
    trip = 1'b0;
    volt = 1'b0;
    dec = 1'b0;
    mf = 8'h00;
    req = '0;
    repeat (8) ck();
    nrst <= 1'b1;
    t_regs();
    t_match();
    t_pullin();
    t_keys();
    t_keypad();
    summarize();
  end
endmodule
